// [rtl/afbp_pkg.sv]
/*
  Constants and types for the asynchronous FIFO / bit-bang parallel port.
  Assumes one core clock at 40 MHz; the controller side of the port is unclocked.
*/
`default_nettype none

// Functional notes
// - FIFO strobes act only while the configuration input selects async FIFO mode.
// - Every FIFO byte transfer is paced by a read or write strobe edge, no port clock.
// - In FIFO mode the data bus stays an input; it is driven only while the read strobe is low.
// - Data-available flag is low while the receive FIFO holds a byte, else high.
// - Data-available goes high after each read; low again only if bytes remain.
// - Read strobe falling edge puts the current receive byte on the data bus.
// - Read strobe rising edge advances to the next receive byte when one exists.
// - Space-available flag is low when the transmit FIFO can take a byte, else high.
// - Each write strobe high-to-low edge captures the data bus into the transmit FIFO.
// - During reset both FIFO flags are undriven and rest high on their pull-ups.
// - Bit-bang mode, set by host command, makes the eight lines a host-driven bus.
// - Bit-bang mode pulses the write indicator low when host data reaches the lines.
// - Bit-bang mode gives the read indicator a rising edge at each line sample.
// - Suspended with wakeup enabled, a low send-now/wake strobe requests USB resume.
// - Not suspended, a low send-now/wake strobe flushes buffered receive data at once.

package afbp_pkg;

  // ****************************************
  // widths and depths
  // ****************************************
  localparam int DATA_W   = 8;
  localparam int RX_DEPTH = 16;
  localparam int CNT_W    = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  // least time the data-available flag stays high after a read
  localparam int RXF_HIGH_NS   = 50;
  localparam int RXF_HIGH_CYC  = (RXF_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // least low time of the bit-bang write indicator
  localparam int BITBANG_WRITE_INDICATOR_N_NS      = 50;
  localparam int BITBANG_WRITE_INDICATOR_N_CYC     = (BITBANG_WRITE_INDICATOR_N_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic       FLAG_IDLE  = 1'b1;
  localparam logic       STRB_IDLE  = 1'b1;
  localparam logic [7:0] DATA_RST   = 8'h00;

  typedef enum logic [1:0] {
    RD_IDLE  = 2'b00,
    RD_DRIVE = 2'b01,
    RD_HOLD  = 2'b11
  } afbp_rd_state_t;

endpackage

`default_nettype wire

// [rtl/afbp_port.sv]
/*
  Asynchronous byte FIFO and bit-bang parallel port, device end, plus a two-entry
  buffer on the transmit path.
  Assumes pin inputs already synchronous except the two FIFO strobes, which are
  resynchronised here; tri-state resolution of pins happens outside.
*/
`default_nettype none

// ****************************************
// two-entry buffer
// ****************************************
module afbp_skid_buf #(
  parameter int W = 8
) (
  input  wire logic         clk,        // core clock
  input  wire logic         rst,        // async reset, high
  input  wire logic [W-1:0] in_data,    // incoming word
  input  wire logic         in_valid,   // incoming word valid
  output logic              in_ready,   // spare entry free
  output logic [W-1:0]      out_data,   // head word
  output logic              out_valid,  // head word valid
  input  wire logic         out_ready   // drain side takes head
);
  logic [W-1:0] head_ff;
  logic [W-1:0] spare_ff;
  logic         head_v_ff;
  logic         spare_v_ff;
  wire          push = in_valid & ~spare_v_ff;
  wire          pop  = head_v_ff & out_ready;
  wire          head_free = pop | ~head_v_ff;

  assign in_ready  = ~spare_v_ff;
  assign out_data  = head_ff;
  assign out_valid = head_v_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      head_ff    <= '0;
      spare_ff   <= '0;
      head_v_ff  <= 1'b0;
      spare_v_ff <= 1'b0;
    end else if (head_free) begin
      if (spare_v_ff) begin
        head_ff    <= spare_ff;
        head_v_ff  <= 1'b1;
        spare_ff   <= in_data;
        spare_v_ff <= push;
      end else begin
        head_ff    <= in_data;
        head_v_ff  <= push;
      end
    end else if (push) begin
      spare_ff   <= in_data;
      spare_v_ff <= 1'b1;
    end
  end
endmodule

// ****************************************
// port top
// ****************************************
module afbp_port
  import afbp_pkg::*;
#(
  parameter int DW    = DATA_W,
  parameter int DEPTH = RX_DEPTH
) (
  input  wire logic          core_clk,                   // core clock, 40 MHz
  input  wire logic          sys_rst,                    // async reset, high
  input  wire logic          async_fifo_mode_sel,        // config memory picks async FIFO
  input  wire logic          bitbang_mode_sel,           // host command picks bit-bang
  input  wire logic          remote_wakeup_en,           // config enables remote wakeup
  input  wire logic [DW-1:0] parallel_data_bus_in,       // data pins, level seen
  output logic [DW-1:0]      parallel_data_bus_out,      // data pins, driven value
  output logic [DW-1:0]      parallel_data_bus_oe,       // data pins, drive enable
  input  wire logic          read_strobe_n,              // controller read strobe
  input  wire logic          write_strobe_n,             // controller write strobe
  output logic               rx_data_available_n,        // receive byte waiting, low
  output logic               rx_data_available_oe,       // flag pin drive enable
  output logic               tx_space_available_n,       // transmit room, low
  output logic               tx_space_available_oe,      // flag pin drive enable
  output logic               bitbang_write_indicator_n,  // host data placed, low pulse
  output logic               bitbang_read_indicator_n,   // rises at each sample
  input  wire logic          send_now_wake_n,            // send-now / wake strobe
  input  wire logic          suspend_indicator_n,        // 1 while bus suspended
  output logic               usb_resume_req,             // resume request pulse
  output logic               send_immediate_req,         // flush receive data pulse
  input  wire logic [DW-1:0] rx_in_data,                 // byte from USB side
  input  wire logic          rx_in_valid,                // byte from USB side valid
  output logic               rx_in_ready,                // receive FIFO has room
  output logic [DW-1:0]      tx_out_data,                // byte toward USB side
  output logic               tx_out_valid,               // byte toward USB valid
  input  wire logic          tx_out_ready,               // USB side takes byte
  input  wire logic [DW-1:0] bb_wr_data,                 // bit-bang output value
  input  wire logic [DW-1:0] bb_wr_dir,                  // bit-bang drive mask, 1 out
  input  wire logic          bb_wr_valid,                // bit-bang write request
  output logic               bb_wr_ready,                // bit-bang write accepted
  input  wire logic          bb_rd_req,                  // bit-bang sample request
  output logic [DW-1:0]      bb_rd_data,                 // sampled lines
  output logic               bb_rd_valid                 // sampled lines valid
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // ****************************************
  // mode decode
  // ****************************************
  wire fifo_mode = async_fifo_mode_sel & ~bitbang_mode_sel;
  wire bb_mode   = bitbang_mode_sel;

  // ****************************************
  // strobe synchronisers
  // ****************************************
  logic [1:0] rd_sync_ff;
  logic [1:0] wr_sync_ff;
  logic       rd_prev_ff;
  logic       wr_prev_ff;
  logic       send_now_wake_n_prev_ff;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_sync_ff   <= {2{STRB_IDLE}};
      wr_sync_ff   <= {2{STRB_IDLE}};
      rd_prev_ff   <= STRB_IDLE;
      wr_prev_ff   <= STRB_IDLE;
      send_now_wake_n_prev_ff <= STRB_IDLE;
    end else begin
      rd_sync_ff   <= {rd_sync_ff[0], read_strobe_n};
      wr_sync_ff   <= {wr_sync_ff[0], write_strobe_n};
      rd_prev_ff   <= rd_sync_ff[1];
      wr_prev_ff   <= wr_sync_ff[1];
      send_now_wake_n_prev_ff <= send_now_wake_n;
    end
  end

  // read and write edges seen only behind the second stage; send-now/wake edge taken straight from the pin
  wire rd_fall = rd_prev_ff & ~rd_sync_ff[1];
  wire rd_rise = ~rd_prev_ff & rd_sync_ff[1];
  wire wr_fall = wr_prev_ff & ~wr_sync_ff[1];
  wire send_now_wake_n_fall = send_now_wake_n_prev_ff & ~send_now_wake_n;

  // ****************************************
  // receive FIFO
  // ****************************************
  logic [DW-1:0]  rx_mem_ff [DEPTH];
  logic [AW-1:0]  rx_wr_idx_ff;
  logic [AW-1:0]  rx_rd_idx_ff;
  logic [CW-1:0]  rx_cnt_ff;
  logic           rx_in_ready_ff;
  afbp_rd_state_t rd_state_ff;
  afbp_rd_state_t nxt_rd_state;
  logic [CNT_W-1:0] hold_cnt_ff;

  wire rx_push = rx_in_valid & rx_in_ready_ff;
  // advance only past a byte that really exists
  wire rx_pop  = (rd_state_ff == RD_DRIVE) & rd_rise & (rx_cnt_ff != '0);
  wire [CW-1:0] nxt_rx_cnt = rx_cnt_ff + CW'(rx_push) - CW'(rx_pop);
  wire [AW-1:0] nxt_wr_idx = (rx_wr_idx_ff == AW'(DEPTH - 1)) ? '0 : rx_wr_idx_ff + 1'b1;
  wire [AW-1:0] nxt_rd_idx = (rx_rd_idx_ff == AW'(DEPTH - 1)) ? '0 : rx_rd_idx_ff + 1'b1;
  wire          hold_done  = (hold_cnt_ff == '0);

  always_comb begin
    case (rd_state_ff)
      RD_IDLE:  nxt_rd_state = (fifo_mode & rd_fall) ? RD_DRIVE : RD_IDLE;
      RD_DRIVE: begin
        if (rd_rise)
          nxt_rd_state = RD_HOLD;
        else if (!fifo_mode)
          nxt_rd_state = RD_IDLE;
        else
          nxt_rd_state = RD_DRIVE;
      end
      RD_HOLD:  nxt_rd_state = hold_done ? RD_IDLE : RD_HOLD;
      default:  nxt_rd_state = RD_IDLE;
    endcase
  end

  wire [CNT_W-1:0] nxt_hold_cnt = (nxt_rd_state == RD_HOLD && rd_state_ff != RD_HOLD) ?
                                  CNT_W'(RXF_HIGH_CYC - 1) :
                                  (hold_done ? '0 : hold_cnt_ff - 1'b1);

  // flag rises with the strobe's return and waits out the hold before falling
  wire nxt_rxf = ~fifo_mode | (nxt_rd_state == RD_HOLD) | (nxt_rx_cnt == '0);

  always_ff @(posedge core_clk) begin
    if (rx_push)
      rx_mem_ff[rx_wr_idx_ff] <= rx_in_data;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_wr_idx_ff   <= '0;
      rx_rd_idx_ff   <= '0;
      rx_cnt_ff      <= '0;
      rx_in_ready_ff <= 1'b0;
      rd_state_ff    <= RD_IDLE;
      hold_cnt_ff    <= '0;
    end else begin
      rx_wr_idx_ff   <= rx_push ? nxt_wr_idx : rx_wr_idx_ff;
      rx_rd_idx_ff   <= rx_pop ? nxt_rd_idx : rx_rd_idx_ff;
      rx_cnt_ff      <= nxt_rx_cnt;
      rx_in_ready_ff <= (nxt_rx_cnt != CW'(DEPTH));
      rd_state_ff    <= nxt_rd_state;
      hold_cnt_ff    <= nxt_hold_cnt;
    end
  end

  // ****************************************
  // transmit capture and buffer
  // ****************************************
  logic          wr_push_ff;
  logic [DW-1:0] wr_data_ff;
  logic          buf_in_ready;

  // bus sampled on the third edge after the strobe fell; controller keeps data steady meanwhile
  wire wr_cap = fifo_mode & wr_fall;
  // a byte on its way counts as taking the room already
  wire nxt_txe = ~fifo_mode | wr_cap | wr_push_ff | ~buf_in_ready;

  afbp_skid_buf #(
    .W (DW)
  ) u_tx_buf (
    .clk       (core_clk),
    .rst       (sys_rst),
    .in_data   (wr_data_ff),
    .in_valid  (wr_push_ff),
    .in_ready  (buf_in_ready),
    .out_data  (tx_out_data),
    .out_valid (tx_out_valid),
    .out_ready (tx_out_ready)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_push_ff <= 1'b0;
      wr_data_ff <= DATA_RST;
    end else begin
      wr_push_ff <= wr_cap;
      wr_data_ff <= wr_cap ? parallel_data_bus_in : wr_data_ff;
    end
  end

  // ****************************************
  // flag pins
  // ****************************************
  logic rxf_ff;
  logic txe_ff;
  logic flag_oe_ff;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxf_ff     <= FLAG_IDLE;
      txe_ff     <= FLAG_IDLE;
      flag_oe_ff <= 1'b0;
    end else begin
      rxf_ff     <= nxt_rxf;
      txe_ff     <= nxt_txe;
      flag_oe_ff <= 1'b1;
    end
  end

  // ****************************************
  // bit-bang
  // ****************************************
  logic [DW-1:0]    bb_dir_ff;
  logic [CNT_W-1:0] wstb_cnt_ff;
  logic             wstb_n_ff;
  logic             bb_wr_ready_ff;
  logic             bb_rd_pend_ff;
  logic             rstb_n_ff;
  logic [DW-1:0]    bb_rd_data_ff;
  logic             bb_rd_valid_ff;

  wire bb_accept = bb_mode & bb_wr_valid & bb_wr_ready_ff;
  wire [DW-1:0] nxt_bb_dir = bb_accept ? bb_wr_dir : bb_dir_ff;
  wire [CNT_W-1:0] nxt_wstb_cnt = bb_accept ? CNT_W'(BITBANG_WRITE_INDICATOR_N_CYC) :
                                  ((wstb_cnt_ff == '0) ? '0 : wstb_cnt_ff - 1'b1);
  wire bb_sample = bb_mode & bb_rd_req;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bb_dir_ff      <= '0;
      wstb_cnt_ff    <= '0;
      wstb_n_ff      <= STRB_IDLE;
      bb_wr_ready_ff <= 1'b0;
      bb_rd_pend_ff  <= 1'b0;
      rstb_n_ff      <= STRB_IDLE;
      bb_rd_data_ff  <= DATA_RST;
      bb_rd_valid_ff <= 1'b0;
    end else begin
      bb_dir_ff      <= nxt_bb_dir;
      wstb_cnt_ff    <= nxt_wstb_cnt;
      wstb_n_ff      <= (nxt_wstb_cnt == '0);
      bb_wr_ready_ff <= bb_mode & (nxt_wstb_cnt == '0);
      bb_rd_pend_ff  <= bb_sample;
      // low for the request cycle, back high on the sampling edge
      rstb_n_ff      <= ~bb_sample;
      bb_rd_data_ff  <= bb_rd_pend_ff ? parallel_data_bus_in : bb_rd_data_ff;
      bb_rd_valid_ff <= bb_rd_pend_ff;
    end
  end

  // ****************************************
  // data bus drive
  // ****************************************
  logic [DW-1:0] bus_out_ff;
  logic [DW-1:0] bus_oe_ff;

  wire rd_present = (rd_state_ff == RD_IDLE) & (nxt_rd_state == RD_DRIVE);
  wire [DW-1:0] nxt_bus_out = bb_accept  ? bb_wr_data :
                              rd_present ? rx_mem_ff[rx_rd_idx_ff] :
                              bus_out_ff;
  // fifo drive only while the read strobe is seen low
  wire [DW-1:0] nxt_bus_oe = bb_mode ? nxt_bb_dir :
                             {DW{nxt_rd_state == RD_DRIVE}};

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_out_ff <= DATA_RST;
      bus_oe_ff  <= '0;
    end else begin
      bus_out_ff <= nxt_bus_out;
      bus_oe_ff  <= nxt_bus_oe;
    end
  end

  // ****************************************
  // send-now / wake
  // ****************************************
  logic resume_ff;
  logic flush_ff;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resume_ff <= 1'b0;
      flush_ff  <= 1'b0;
    end else begin
      resume_ff <= send_now_wake_n_fall & suspend_indicator_n & remote_wakeup_en;
      flush_ff  <= send_now_wake_n_fall & ~suspend_indicator_n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign parallel_data_bus_out     = bus_out_ff;
  assign parallel_data_bus_oe      = bus_oe_ff;
  assign rx_data_available_n       = rxf_ff;
  assign rx_data_available_oe      = flag_oe_ff;
  assign tx_space_available_n      = txe_ff;
  assign tx_space_available_oe     = flag_oe_ff;
  assign bitbang_write_indicator_n = wstb_n_ff;
  assign bitbang_read_indicator_n  = rstb_n_ff;
  assign usb_resume_req            = resume_ff;
  assign send_immediate_req        = flush_ff;
  assign rx_in_ready               = rx_in_ready_ff;
  assign bb_wr_ready               = bb_wr_ready_ff;
  assign bb_rd_data                = bb_rd_data_ff;
  assign bb_rd_valid               = bb_rd_valid_ff;

endmodule

`default_nettype wire

// [tb/afbp_port_chk.sv]
/*
  Assertions on the ports of the parallel port top, bound to every instance.
  Assumes strobes idle high and the bench holds each mode steady while it works.
*/
`default_nettype none
module afbp_port_chk
  import afbp_pkg::*;
#(
  parameter int DW    = DATA_W,
  parameter int DEPTH = RX_DEPTH
) (
  input wire logic          core_clk,                   // clock
  input wire logic          sys_rst,                    // reset
  input wire logic          async_fifo_mode_sel,        // fifo mode
  input wire logic          bitbang_mode_sel,           // bit-bang mode
  input wire logic          remote_wakeup_en,           // wakeup enable
  input wire logic [DW-1:0] parallel_data_bus_in,       // pin level
  input wire logic [DW-1:0] parallel_data_bus_out,      // pin value
  input wire logic [DW-1:0] parallel_data_bus_oe,       // pin enable
  input wire logic          read_strobe_n,              // read strobe
  input wire logic          write_strobe_n,             // write strobe
  input wire logic          rx_data_available_n,        // rx flag
  input wire logic          rx_data_available_oe,       // rx flag enable
  input wire logic          tx_space_available_n,       // tx flag
  input wire logic          tx_space_available_oe,      // tx flag enable
  input wire logic          bitbang_write_indicator_n,  // write pulse
  input wire logic          bitbang_read_indicator_n,   // read pulse
  input wire logic          send_now_wake_n,            // wake strobe
  input wire logic          suspend_indicator_n,        // suspended
  input wire logic          usb_resume_req,             // resume pulse
  input wire logic          send_immediate_req,         // flush pulse
  input wire logic [DW-1:0] tx_out_data,                // tx head
  input wire logic          tx_out_valid,               // tx head valid
  input wire logic [DW-1:0] bb_wr_data,                 // bb value
  input wire logic [DW-1:0] bb_wr_dir,                  // bb mask
  input wire logic          bb_wr_valid,                // bb write
  input wire logic          bb_wr_ready,                // bb accept
  input wire logic          bb_rd_req,                  // bb sample
  input wire logic [DW-1:0] bb_rd_data,                 // bb result
  input wire logic          bb_rd_valid                 // bb result valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // properties
  // ****************************************
  wire fifo_on = async_fifo_mode_sel & ~bitbang_mode_sel;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_flags_reset_float: assert property (disable iff (1'b0)
    sys_rst |-> !rx_data_available_oe && !tx_space_available_oe) else $error("flag driven in reset");
  a_flags_idle_high: assert property (
    (!fifo_on) [*3] |-> rx_data_available_n && tx_space_available_n) else $error("flag low off mode");
  a_bus_drive_window: assert property (
    fifo_on && (|parallel_data_bus_oe) |-> !$past(read_strobe_n, 3)) else $error("bus driven early");
  a_read_present: assert property (
    $fell(read_strobe_n) && fifo_on |-> ##3 parallel_data_bus_oe == {DW{1'b1}})
    else $error("read byte not driven");
  a_read_end_flag: assert property (
    $rose(read_strobe_n) && fifo_on |-> ##3 parallel_data_bus_oe == '0 && rx_data_available_n [*2])
    else $error("flag not raised after read");
  a_write_busy_flag: assert property (
    $fell(write_strobe_n) && fifo_on |-> ##3 tx_space_available_n) else $error("room flag stayed low");
  a_write_capture: assert property (
    $fell(write_strobe_n) && fifo_on && !tx_out_valid |-> ##5
    tx_out_valid && tx_out_data == $past(parallel_data_bus_in, 3)) else $error("write byte lost");
  a_bb_write_pulse: assert property (
    bitbang_mode_sel && bb_wr_valid && bb_wr_ready |=> parallel_data_bus_out == $past(bb_wr_data)
    && parallel_data_bus_oe == $past(bb_wr_dir) && !bitbang_write_indicator_n
    ##1 !bitbang_write_indicator_n ##1 bitbang_write_indicator_n) else $error("bad write pulse");
  a_bb_read_rise: assert property (
    bitbang_mode_sel && bb_rd_req |=> !bitbang_read_indicator_n ##1 $rose(bitbang_read_indicator_n)
    && bb_rd_valid && bb_rd_data == $past(parallel_data_bus_in)) else $error("bad read sample");
  a_wake_resume: assert property (
    $fell(send_now_wake_n) && suspend_indicator_n && remote_wakeup_en |-> ##[1:2] usb_resume_req)
    else $error("no resume request");
  a_wake_flush: assert property (
    $fell(send_now_wake_n) && !suspend_indicator_n |-> ##[1:2] send_immediate_req)
    else $error("no flush request");

  c_read: cover property ($rose(read_strobe_n) && fifo_on);
  c_write: cover property ($fell(write_strobe_n) && fifo_on);
  c_bb_read: cover property (bb_rd_valid);
endmodule

bind afbp_port afbp_port_chk #(.DW(DW), .DEPTH(DEPTH)) u_chk (.*);
`default_nettype wire

// [tb/afbp_ctrl_model.sv]
/*
  External controller on the async fifo side: strobes and the lines it drives.
  Assumes the bench resolves the pins and calls the tasks at falling clock edges.
*/
`default_nettype none
module afbp_ctrl_model
  import afbp_pkg::*;
(
  input  wire logic              core_clk,  // core clock
  input  wire logic              rxf_n,     // data available flag
  input  wire logic              txe_n,     // room available flag
  input  wire logic [DATA_W-1:0] pins,      // resolved pin level
  output var  logic              rd_n,      // read strobe
  output var  logic              wr_n,      // write strobe
  output var  logic [DATA_W-1:0] drv        // level of lines we own
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    drv  = 8'h00;
  end
  // ****************************************
  // transfers
  // ****************************************
  task automatic rd_byte(output logic [DATA_W-1:0] b, input int slow);
    int n;
    n = 0;
    while (rxf_n !== 1'b0 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    rd_n = 1'b0;
    repeat (4 + slow) @(posedge core_clk);
    b = pins;
    @(negedge core_clk);
    rd_n = 1'b1;
    // flag is stale until the rise has crossed the synchroniser
    repeat (4) @(negedge core_clk);
  endtask

  task automatic wr_byte(input logic [DATA_W-1:0] b, input int slow);
    int n;
    n = 0;
    while (txe_n !== 1'b0 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    drv  = b;
    wr_n = 1'b0;
    repeat (4 + slow) @(negedge core_clk);
    wr_n = 1'b1;
    drv  = ~b;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic put(input logic [DATA_W-1:0] v);
    drv = v;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
/*
  Self-checking bench for the parallel port top with the controller model.
  Assumes a 40 MHz core clock; inputs change on falling edges only.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import afbp_pkg::*;
  localparam int MAX_CYC = 20000;
  logic       core_clk, sys_rst, async_fifo_mode_sel, bitbang_mode_sel, remote_wakeup_en;
  logic       read_strobe_n, write_strobe_n, rx_data_available_n, rx_data_available_oe;
  logic       tx_space_available_n, tx_space_available_oe, bitbang_write_indicator_n;
  logic       bitbang_read_indicator_n, send_now_wake_n, suspend_indicator_n, usb_resume_req;
  logic       send_immediate_req, rx_in_valid, rx_in_ready, tx_out_valid, tx_out_ready;
  logic       bb_wr_valid, bb_wr_ready, bb_rd_req, bb_rd_valid;
  logic [7:0] parallel_data_bus_in, parallel_data_bus_out, parallel_data_bus_oe, line_drv;
  logic [7:0] rx_in_data, tx_out_data, bb_wr_data, bb_wr_dir, bb_rd_data;
  int         fails, n_compared;
  int         cyc = 0;

  afbp_port dut_u (.*);
  afbp_ctrl_model u_ctl (.core_clk, .rxf_n(rx_data_available_n), .txe_n(tx_space_available_n),
    .pins(parallel_data_bus_in), .rd_n(read_strobe_n), .wr_n(write_strobe_n), .drv(line_drv));
  // each line shows whoever drives it
  assign parallel_data_bus_in = (parallel_data_bus_oe & parallel_data_bus_out)
                              | (~parallel_data_bus_oe & line_drv);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == MAX_CYC) begin
      fails++;
      finish_test();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk_bit(rx_data_available_oe, 1'b0);
    chk_bit(tx_space_available_oe, 1'b0);
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_bit(rx_data_available_n, 1'b1);
    chk_bit(tx_space_available_n, 1'b1);
    u_ctl.wr_byte(8'h77, 0);
    chk_bit(tx_out_valid, 1'b0);
  endtask
  task automatic t_rx_read();
    logic [7:0] v[3];
    logic [7:0] b;
    v = '{8'h5A, 8'hC3, 8'h0F};
    async_fifo_mode_sel = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wait_hi(rx_in_ready);
      rx_in_data  = v[i];
      rx_in_valid = 1'b1;
      @(negedge core_clk);
      rx_in_valid = 1'b0;
      @(negedge core_clk);
    end
    repeat (4) @(negedge core_clk);
    chk_bit(rx_data_available_n, 1'b0);
    for (int i = 0; i < 3; i++) begin
      u_ctl.rd_byte(b, i);
      chk_byte(b, v[i]);
    end
    chk_byte(parallel_data_bus_oe, 8'h00);
    repeat (4) @(negedge core_clk);
    chk_bit(rx_data_available_n, 1'b1);
  endtask
  task automatic t_tx_write();
    logic [7:0] w[2];
    w = '{8'h96, 8'h3B};
    tx_out_ready = 1'b0;
    u_ctl.wr_byte(w[0], 0);
    u_ctl.wr_byte(w[1], 2);
    repeat (2) @(negedge core_clk);
    chk_bit(tx_space_available_n, 1'b1);
    tx_out_ready = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wait_hi(tx_out_valid);
      chk_byte(tx_out_data, w[i]);
      @(negedge core_clk);
    end
    repeat (4) @(negedge core_clk);
    chk_bit(tx_space_available_n, 1'b0);
  endtask
  task automatic t_bitbang();
    bitbang_mode_sel = 1'b1;
    @(negedge core_clk);
    wait_hi(bb_wr_ready);
    bb_wr_data  = 8'hA5;
    bb_wr_dir   = 8'hF0;
    bb_wr_valid = 1'b1;
    @(negedge core_clk);
    bb_wr_valid = 1'b0;
    chk_byte(parallel_data_bus_out, 8'hA5);
    chk_byte(parallel_data_bus_oe, 8'hF0);
    chk_bit(bitbang_write_indicator_n, 1'b0);
    repeat (2) @(negedge core_clk);
    chk_bit(bitbang_write_indicator_n, 1'b1);
    u_ctl.put(8'h3C);
    bb_rd_req = 1'b1;
    @(negedge core_clk);
    bb_rd_req = 1'b0;
    chk_bit(bitbang_read_indicator_n, 1'b0);
    @(negedge core_clk);
    chk_bit(bitbang_read_indicator_n, 1'b1);
    chk_bit(bb_rd_valid, 1'b1);
    chk_byte(bb_rd_data, 8'hAC);
  endtask
  task automatic t_wake();
    logic [2:0] sp, en, er, es;
    logic r, s;
    sp = 3'h5;
    en = 3'h3;
    er = 3'h1;
    es = 3'h2;
    for (int i = 0; i < 3; i++) begin
      suspend_indicator_n = sp[i];
      remote_wakeup_en    = en[i];
      @(negedge core_clk);
      r = 1'b0;
      s = 1'b0;
      send_now_wake_n = 1'b0;
      repeat (3) begin
        @(negedge core_clk);
        r = r | usb_resume_req;
        s = s | send_immediate_req;
      end
      send_now_wake_n = 1'b1;
      @(negedge core_clk);
      chk_bit(r, er[i]);
      chk_bit(s, es[i]);
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    async_fifo_mode_sel = 1'b0;
    bitbang_mode_sel = 1'b0;
    remote_wakeup_en = 1'b0;
    send_now_wake_n = 1'b1;
    suspend_indicator_n = 1'b0;
    rx_in_valid = 1'b0;
    rx_in_data = 8'h00;
    tx_out_ready = 1'b0;
    bb_wr_valid = 1'b0;
    bb_wr_data = 8'h00;
    bb_wr_dir = 8'h00;
    bb_rd_req = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (10) @(negedge core_clk);
    t_reset();
    t_rx_read();
    t_tx_write();
    t_bitbang();
    t_wake();
    finish_test();
  end
endmodule
`default_nettype wire
